/* File: design/ssm_pkg.sv */
// Constants, codes and field layout for the subrate slot multiplexer.
// Assumes one 125 MHz clock and a plain word-wide register port.
package ssm_pkg;
  localparam int NSEG = 20;
  localparam int NTS = 32;
  localparam int CLK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam int CTS_30_MS = 30;
  localparam int CTS_60_MS = 60;
  localparam int CTS_100_MS = 100;

  localparam logic [7:0] ADR_CFG0 = 8'h00;
  localparam logic [7:0] ADR_OPT = 8'h28;
  localparam logic [7:0] ADR_STAT = 8'h40;
  localparam logic [7:0] ADR_BW = 8'h44;
  localparam logic [7:0] ADR_CODEC = 8'h48;
  localparam logic [7:0] ADR_MPTR = 8'h4c;
  localparam logic [7:0] ADR_MOWN = 8'h50;
  localparam logic [7:0] ADR_LEAD = 8'h54;

  // Port configuration word fields
  localparam int F_ACT = 0;
  localparam int F_WAN = 1;
  localparam int F_TS = 4;
  localparam int F_FRM = 9;
  localparam int F_RATE = 12;
  localparam int F_SRI = 16;
  localparam int F_LINE_PROTOCOL_SELECT = 21;
  localparam int F_DBIT = 23;
  localparam int F_STOP = 25;
  localparam int F_PAR = 26;
  localparam int F_CTS = 29;
  localparam logic [31:0] CFG_RST = 32'h0001_0010;
  localparam int OPT_BERT = 10;

  localparam logic [2:0] FR_A = 3'h0;
  localparam logic [2:0] FR_B5 = 3'h1;
  localparam logic [2:0] FR_B10 = 3'h2;
  localparam logic [2:0] FR_B20 = 3'h3;
  localparam logic [2:0] FR_X50 = 3'h4;
  localparam logic [2:0] FR_ADPCM = 3'h5;
  localparam logic [2:0] FR_HLINK = 3'h6;
  localparam logic [2:0] FR_NLINK = 3'h7;

  localparam logic [3:0] RT_0K3 = 4'h0;
  localparam logic [3:0] RT_1K2 = 4'h1;
  localparam logic [3:0] RT_2K4 = 4'h2;
  localparam logic [3:0] RT_4K8 = 4'h3;
  localparam logic [3:0] RT_9K6 = 4'h4;
  localparam logic [3:0] RT_14K4 = 4'h5;
  localparam logic [3:0] RT_19K2 = 4'h6;
  localparam logic [3:0] RT_28K8 = 4'h7;
  localparam logic [3:0] RT_38K4 = 4'h8;

  localparam logic [1:0] IF_ASYNC = 2'h0;
  localparam logic [1:0] IF_SYNC = 2'h1;
  localparam logic [1:0] IF_V14 = 2'h2;

  localparam logic [2:0] PAR_NONE = 3'h0;

  localparam logic [2:0] CTS_PERM = 3'h0;
  localparam logic [2:0] CTS_OFF = 3'h1;
  localparam logic [2:0] CTS_L0 = 3'h2;
  localparam logic [2:0] CTS_L30 = 3'h3;
  localparam logic [2:0] CTS_L60 = 3'h4;
  localparam logic [2:0] CTS_L100 = 3'h5;
  localparam logic [2:0] CTS_RL0 = 3'h6;
  localparam logic [2:0] CTS_RL100 = 3'h7;

  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_TS = 3'h1;
  localparam logic [2:0] RES_WAN = 3'h2;
  localparam logic [2:0] RES_SRI = 3'h3;
  localparam logic [2:0] RES_OVL = 3'h4;
  localparam logic [2:0] RES_BW = 3'h5;
  localparam logic [2:0] RES_RATE = 3'h6;

  localparam logic [3:0] OWN_FREE = 4'hf;
  localparam logic [3:0] OWN_FOREIGN = 4'he;

  localparam logic [4:0] T1_MAX_TS = 5'h18;
  localparam logic [4:0] E1_MAX_TS = 5'h1f;
  localparam logic [4:0] E1_SIG_TS = 5'h10;

  // Bandwidth in units of 0.1 kbps times BW_SCALE
  localparam int BW_KBPS_X10 = 1152;
  localparam int W_SYNC = 10;
  localparam int W_ASYNC = 12;
  localparam int W_V14 = 16;
  localparam int W_NODL = 2;
  localparam int W_DL = 3;
  localparam int W_BERT = 2;
  localparam int BW_SCALE = W_SYNC * W_NODL;
  localparam logic [19:0] BW_LIMIT = 20'(BW_KBPS_X10 * BW_SCALE);
  localparam logic [15:0] CODEC_KBPS_X10 = 16'h00f0;
endpackage

/* File: design/ssm_circuit_check.sv */
// Per-circuit check: segment mask, range checks and weighted bandwidth.
// Purely combinational; the caller adds the cross-port checks.
`timescale 1ns/10ps
module ssm_circuit_check (
  input wire logic [2:0] i_frame,
  input wire logic [3:0] i_rate,
  input wire logic [4:0] i_sri,
  input wire logic [1:0] i_line_protocol_select,
  input wire logic [4:0] i_ts,
  input wire logic i_is_e1,
  input wire logic i_ts16_sig,
  input wire logic i_dl_opt,
  input wire logic i_bert,
  output logic [ssm_pkg::NSEG-1:0] o_mask,
  output logic [19:0] o_weight,
  output logic o_uses_map,
  output logic [2:0] o_err
);
  import ssm_pkg::*;
  logic [4:0] cap;
  logic [4:0] segs;
  logic [4:0] first;
  logic [5:0] last;
  logic [8:0] rx10;
  logic [4:0] iw;
  logic x50;

  always_comb begin
    x50 = (i_frame == FR_X50);
    o_uses_map = (i_frame != FR_ADPCM) && (i_frame != FR_HLINK);
    case (i_rate)
      RT_0K3: rx10 = 9'd3;
      RT_1K2: rx10 = 9'd12;
      RT_2K4: rx10 = 9'd24;
      RT_4K8: rx10 = 9'd48;
      RT_9K6: rx10 = 9'd96;
      RT_14K4: rx10 = 9'd144;
      RT_19K2: rx10 = 9'd192;
      RT_28K8: rx10 = 9'd288;
      default: rx10 = 9'd384;
    endcase
    case (i_rate)
      RT_14K4, RT_19K2: segs = 5'd2;
      RT_28K8: segs = 5'd3;
      RT_38K4: segs = 5'd4;
      default: segs = 5'd1;
    endcase
    case (i_frame)
      FR_B5: cap = 5'd5;
      FR_B10: cap = 5'd10;
      FR_B20: cap = 5'd20;
      FR_X50: begin
        case (i_rate)
          RT_2K4: cap = 5'd20;
          RT_4K8: cap = 5'd10;
          default: cap = 5'd5;
        endcase
      end
      default: cap = 5'd1;
    endcase
    first = i_sri - 5'd1;
    last = x50 ? {1'b0, i_sri} : 6'({1'b0, i_sri} + {1'b0, segs} - 6'd1);
    for (int k = 0; k < NSEG; k++) begin
      if (x50) begin
        o_mask[k] = (5'(k) >= first) &&
          (5'(k % 5) == first || cap != 5'd5) &&
          (5'(k % 10) == first || cap != 5'd10) &&
          (5'(k) == first || cap != 5'd20);
      end else begin
        o_mask[k] = (5'(k) >= first) &&
          (6'(k) < 6'({1'b0, first} + {1'b0, segs}));
      end
    end
    if (!o_uses_map) begin
      o_mask = '0;
    end
    case (i_line_protocol_select)
      IF_SYNC: iw = 5'(W_SYNC);
      IF_V14: iw = 5'(W_V14);
      default: iw = 5'(W_ASYNC);
    endcase
    o_weight = 20'(rx10) * 20'(iw) * (i_dl_opt ? 20'(W_DL) : 20'(W_NODL)) *
      (i_bert ? 20'(W_BERT) : 20'h1);
    o_err = RES_OK;
    if (o_uses_map && (i_ts == 5'h0 ||
        i_ts > (i_is_e1 ? E1_MAX_TS : T1_MAX_TS) ||
        (i_is_e1 && i_ts16_sig && i_ts == E1_SIG_TS))) begin
      o_err = RES_TS;
    end else if (i_line_protocol_select == IF_SYNC && (i_rate == RT_0K3 ||
        i_rate == RT_1K2 || (i_rate == RT_14K4 && o_uses_map))) begin
      o_err = RES_RATE;
    end else if (x50 && i_rate != RT_2K4 && i_rate != RT_4K8 &&
        i_rate != RT_9K6) begin
      o_err = RES_RATE;
    end else if (o_uses_map && (i_sri == 5'h0 ||
        last > {1'b0, cap})) begin
      o_err = RES_SRI;
    end
  end
endmodule

/* File: design/ssm_top.sv */
// Subrate slot multiplexer: port configuration, occupancy map, checks
// and control leads. Assumes a register master that never waits.
// Overview of operation
// - Standby drops RLSD and CTS; active raises RLSD, or copies remote RTS in CTS_RL0/CTS_RL100; link down drops RLSD.
// - Time slot 1-24 on T1, 1-31 on E1, 16 barred with signalling.
// - One WAN slot splits into at most twenty 2.4 kbps segments.
// - Same slot number on two WAN links from one card is refused.
// - Framing sets capacity: a gives one, b variants five, ten, twenty.
// - Twenty-segment slots may be shared with other cards' segments.
// - Codec-multiplex ports use a 24 kbps share of the codec engine.
// - Refuse any change pushing total sync bandwidth over 115.2 kbps.
// - Weights: async 1.2, v.14 1.6, delay opt 1.5, BERT 2.
// - Above 9.6 kbps a circuit takes one segment per 9.6 kbps.
// - Subrate index range follows framing; unused for codec framings.
// - Index is the first segment; further segments go upward.
// - Circuit running past the last segment gives invalid index error.
// - Colliding with segments held by another circuit gives overlap error.
// - x.50 has 20, 10 or 5 slots at 2.4, 4.8, 9.6 kbps.
// - x.50 interleave: n; n and n+10; n, n+5, n+10, n+15.
// - Sync ports refuse 0.3, 1.2, 14.4 except 14.4 on codec framings.
// - Sync ports ignore data, stop and parity settings.
// - Async and v.14 modes convert start-stop to a sync stream.
// - Async characters: 5-8 data, 1-2 stop, five parity choices.
// - Low-delay variant has no delay optimization.
// - CTS permanent, off, or follows RTS after 0, 30, 60, 100 ms.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
module ssm_top #(
  parameter int NPORT = 10,
  parameter int MS_CYCLES = ssm_pkg::MS_CYC,
  parameter bit LOW_DELAY = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [7:0] i_wan_up,
  input wire logic [7:0] i_wan_is_e1,
  input wire logic [7:0] i_wan_ts16_sig,
  input wire logic [NPORT-1:0] i_rts,
  input wire logic [NPORT-1:0] i_remote_rts,
  output logic [NPORT-1:0] o_rlsd,
  output logic [NPORT-1:0] o_cts,
  output logic [NPORT-1:0] o_rts_to_remote,
  output logic [NPORT-1:0] o_conv_on,
  output logic [NPORT-1:0] o_conv_v14,
  output logic [NPORT-1:0] o_codec_req,
  output logic [4*NPORT-1:0] o_char_len,
  input wire logic [4:0] i_mux_ts,
  input wire logic [4:0] i_mux_seg,
  output logic [3:0] o_mux_owner
);
  import ssm_pkg::*;

  logic [31:0] cfg_r [NPORT];
  logic [19:0] weight_r [NPORT];
  logic [3:0] map_r [NTS][NSEG];
  logic [19:0] opt_r;
  logic [2:0] stat_r;
  logic [9:0] mptr_r;
  logic [16:0] ms_cnt_r;
  logic ms_tick;
  logic [6:0] dly_r [NPORT];

  logic [3:0] wp;
  logic cfg_wr;
  logic [31:0] nc;
  logic [2:0] n_wan;
  logic [4:0] n_ts;
  logic n_act;
  logic [NSEG-1:0] n_mask;
  logic [19:0] n_weight;
  logic n_uses_map;
  logic [2:0] loc_err;
  logic [2:0] chk_res;
  logic wan_clash;
  logic ovl;
  logic [19:0] bw_others;
  logic [19:0] bw_total;
  logic [15:0] codec_total;
  logic [4:0] ptr_ts;
  logic [4:0] ptr_seg;

  assign wp = i_addr[5:2];
  assign cfg_wr = i_wr && i_addr[7:6] == 2'h0 && i_addr[1:0] == 2'h0 &&
    32'(wp) < NPORT;
  assign nc = i_wdata;
  assign n_wan = nc[F_WAN +: 3];
  assign n_ts = nc[F_TS +: 5];
  assign n_act = nc[F_ACT];
  assign ptr_ts = mptr_r[9:5];
  assign ptr_seg = mptr_r[4:0];

  ssm_circuit_check u_chk (
    .i_frame(nc[F_FRM +: 3]),
    .i_rate(nc[F_RATE +: 4]),
    .i_sri(nc[F_SRI +: 5]),
    .i_line_protocol_select(nc[F_LINE_PROTOCOL_SELECT +: 2]),
    .i_ts(n_ts),
    .i_is_e1(i_wan_is_e1[n_wan]),
    .i_ts16_sig(i_wan_ts16_sig[n_wan]),
    .i_dl_opt(opt_r[wp]),
    .i_bert(opt_r[OPT_BERT + 32'(wp)]),
    .o_mask(n_mask),
    .o_weight(n_weight),
    .o_uses_map(n_uses_map),
    .o_err(loc_err)
  );

  // Cross-port checks against what is already committed
  always_comb begin
    wan_clash = 1'b0;
    ovl = 1'b0;
    bw_others = '0;
    bw_total = '0;
    codec_total = '0;
    for (int j = 0; j < NPORT; j++) begin
      bw_total = bw_total + weight_r[j];
      if (cfg_r[j][F_FRM +: 3] == FR_ADPCM && cfg_r[j][F_ACT]) begin
        codec_total = codec_total + CODEC_KBPS_X10;
      end
      if (j != 32'(wp)) begin
        bw_others = bw_others + weight_r[j];
        if (cfg_r[j][F_ACT] && n_uses_map &&
            cfg_r[j][F_FRM +: 3] != FR_ADPCM &&
            cfg_r[j][F_FRM +: 3] != FR_HLINK &&
            cfg_r[j][F_TS +: 5] == n_ts &&
            (cfg_r[j][F_WAN +: 3] != n_wan ||
             (cfg_r[j][F_FRM +: 3] != nc[F_FRM +: 3] &&
              nc[F_FRM +: 3] != FR_X50))) begin
          wan_clash = 1'b1;
        end
      end
    end
    for (int s = 0; s < NSEG; s++) begin
      if (n_mask[s] && map_r[n_ts][s] != OWN_FREE &&
          map_r[n_ts][s] != 4'(wp)) begin
        ovl = 1'b1;
      end
    end
    if (!n_act) begin
      chk_res = RES_OK;
    end else if (loc_err != RES_OK) begin
      chk_res = loc_err;
    end else if (wan_clash) begin
      chk_res = RES_WAN;
    end else if (ovl) begin
      chk_res = RES_OVL;
    end else if (bw_others + n_weight > BW_LIMIT) begin
      chk_res = RES_BW;
    end else begin
      chk_res = RES_OK;
    end
  end

  // Committed port configuration and weight
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int j = 0; j < NPORT; j++) begin
        cfg_r[j] <= CFG_RST;
        weight_r[j] <= '0;
      end
    end else if (cfg_wr && chk_res == RES_OK) begin
      cfg_r[wp] <= nc;
      weight_r[wp] <= n_act ? n_weight : 20'h0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stat_r <= RES_OK;
    end else if (cfg_wr) begin
      stat_r <= chk_res;
    end
  end

  // Occupancy map; a port's old segments are released on every commit
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int t = 0; t < NTS; t++) begin
        for (int s = 0; s < NSEG; s++) begin
          map_r[t][s] <= OWN_FREE;
        end
      end
    end else if (cfg_wr && chk_res == RES_OK) begin
      for (int t = 0; t < NTS; t++) begin
        for (int s = 0; s < NSEG; s++) begin
          if (n_act && n_uses_map && 5'(t) == n_ts && n_mask[s]) begin
            map_r[t][s] <= 4'(wp);
          end else if (map_r[t][s] == 4'(wp)) begin
            map_r[t][s] <= OWN_FREE;
          end
        end
      end
    end else if (i_wr && i_addr == ADR_MOWN && 32'(ptr_seg) < NSEG &&
        (map_r[ptr_ts][ptr_seg] == OWN_FREE ||
         map_r[ptr_ts][ptr_seg] == OWN_FOREIGN)) begin
      // Segments held by other cards sharing the slot
      map_r[ptr_ts][ptr_seg] <= i_wdata[0] ? OWN_FOREIGN : OWN_FREE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      opt_r <= '0;
      mptr_r <= '0;
    end else begin
      if (i_wr && i_addr == ADR_OPT) begin
        // Delay option cannot be set on the low-delay build
        opt_r[NPORT-1:0] <= LOW_DELAY ? '0 : i_wdata[NPORT-1:0];
        opt_r[OPT_BERT +: NPORT] <= i_wdata[OPT_BERT +: NPORT];
      end
      if (i_wr && i_addr == ADR_MPTR) begin
        mptr_r <= i_wdata[9:0];
      end
    end
  end

  // Map lookup for the time slot multiplexer
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_mux_owner <= OWN_FREE;
    end else if (32'(i_mux_seg) < NSEG) begin
      o_mux_owner <= map_r[i_mux_ts][i_mux_seg];
    end else begin
      o_mux_owner <= OWN_FREE;
    end
  end

  // Register read, data valid only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_reset || !i_rd) begin
      o_rdata <= '0;
    end else if (i_addr[7:6] == 2'h0 && 32'(wp) < NPORT &&
        i_addr[1:0] == 2'h0) begin
      o_rdata <= cfg_r[wp];
    end else begin
      case (i_addr)
        ADR_OPT: o_rdata <= {12'h0, opt_r};
        ADR_STAT: o_rdata <= {29'h0, stat_r};
        ADR_BW: o_rdata <= {12'h0, bw_total};
        ADR_CODEC: o_rdata <= {16'h0, codec_total};
        ADR_MPTR: o_rdata <= {22'h0, mptr_r};
        ADR_MOWN: o_rdata <= (32'(ptr_seg) < NSEG) ?
          {28'h0, map_r[ptr_ts][ptr_seg]} : 32'h0;
        ADR_LEAD: o_rdata <= 32'({o_cts, o_rlsd});
        default: o_rdata <= 32'h0;
      endcase
    end
  end

  // Shared millisecond tick for CTS delays
  always_ff @(posedge i_clk) begin
    if (i_reset || ms_tick) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + 17'h1;
    end
  end
  assign ms_tick = (32'(ms_cnt_r) == MS_CYCLES - 1);

  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      logic act;
      logic up;
      logic [2:0] mode;
      logic [6:0] target;
      logic async_if;
      logic [3:0] dbits;

      assign act = cfg_r[gp][F_ACT];
      assign up = i_wan_up[cfg_r[gp][F_WAN +: 3]];
      assign mode = cfg_r[gp][F_CTS +: 3];
      assign async_if = cfg_r[gp][F_LINE_PROTOCOL_SELECT +: 2] != IF_SYNC;

      always_comb begin
        case (mode)
          CTS_L30: target = 7'(CTS_30_MS);
          CTS_L60: target = 7'(CTS_60_MS);
          CTS_L100, CTS_RL100: target = 7'(CTS_100_MS);
          default: target = 7'h0;
        endcase
      end

      // Delay runs only while RTS stays high
      always_ff @(posedge i_clk) begin
        if (i_reset || !i_rts[gp]) begin
          dly_r[gp] <= '0;
        end else if (ms_tick && dly_r[gp] < target) begin
          dly_r[gp] <= dly_r[gp] + 7'h1;
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_reset || !act) begin
          o_cts[gp] <= 1'b0;
          o_rlsd[gp] <= 1'b0;
          o_rts_to_remote[gp] <= 1'b0;
        end else begin
          case (mode)
            CTS_PERM: o_cts[gp] <= 1'b1;
            CTS_OFF: o_cts[gp] <= 1'b0;
            default: o_cts[gp] <= i_rts[gp] && dly_r[gp] >= target;
          endcase
          if (!up) begin
            o_rlsd[gp] <= 1'b0;
          end else if (mode == CTS_RL0 || mode == CTS_RL100) begin
            o_rlsd[gp] <= i_remote_rts[gp];
          end else begin
            o_rlsd[gp] <= 1'b1;
          end
          o_rts_to_remote[gp] <= up && i_rts[gp] &&
            (mode == CTS_RL0 || mode == CTS_RL100);
        end
      end

      // Converter setup; sync ports see no character format
      assign dbits = 4'h8 - {2'h0, cfg_r[gp][F_DBIT +: 2]};
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          o_conv_on[gp] <= 1'b0;
          o_conv_v14[gp] <= 1'b0;
          o_codec_req[gp] <= 1'b0;
          o_char_len[4*gp +: 4] <= 4'h0;
        end else begin
          o_conv_on[gp] <= act && async_if;
          o_conv_v14[gp] <= act &&
            cfg_r[gp][F_LINE_PROTOCOL_SELECT +: 2] == IF_V14;
          o_codec_req[gp] <= act &&
            cfg_r[gp][F_FRM +: 3] == FR_ADPCM;
          if (async_if) begin
            o_char_len[4*gp +: 4] <= 4'h1 + dbits +
              {3'h0, cfg_r[gp][F_PAR +: 3] != PAR_NONE} +
              {3'h0, 1'b1} + {3'h0, cfg_r[gp][F_STOP]};
          end else begin
            o_char_len[4*gp +: 4] <= 4'h0;
          end
        end
      end
    end
  endgenerate
endmodule

/* File: verif/ssm_far_end.sv */
// Far side model: WAN link state and the attached terminals' RTS leads.
// Assumes the bench steers link state and RTS through the control inputs.
`timescale 1ns/10ps
module ssm_far_end #(
  parameter int NPORT = 10
) (
  input wire logic i_clk,
  input wire logic [7:0] i_up_ctl,
  input wire logic [NPORT-1:0] i_rts_ctl,
  input wire logic [NPORT-1:0] i_rrts_ctl,
  output logic [7:0] o_wan_up,
  output logic [7:0] o_wan_is_e1,
  output logic [7:0] o_wan_ts16_sig,
  output logic [NPORT-1:0] o_rts,
  output logic [NPORT-1:0] o_remote_rts
);
  // Link 0 is T1, link 1 E1 signalling in slot 16, link 2 plain E1
  assign o_wan_is_e1 = 8'h06;
  assign o_wan_ts16_sig = 8'h02;
  // Lead changes land one edge late, as through a real bus
  always @(posedge i_clk) begin
    o_wan_up <= i_up_ctl;
    o_rts <= i_rts_ctl;
    o_remote_rts <= i_rrts_ctl;
  end
endmodule

/* File: verif/ssm_top_properties.sv */
// Port-level checks for the subrate slot multiplexer.
// Bound into every ssm_top; sees only its ports.
`timescale 1ns/10ps
module ssm_top_checker
  import ssm_pkg::*;
#(
  parameter int NPORT = 10
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [7:0] i_wan_up,
  input wire logic [NPORT-1:0] o_rlsd,
  input wire logic [NPORT-1:0] o_cts,
  input wire logic [NPORT-1:0] o_conv_on,
  input wire logic [NPORT-1:0] o_codec_req,
  input wire logic [4*NPORT-1:0] o_char_len,
  input wire logic [3:0] o_mux_owner
);
  logic bad_len;
  // Start, data, parity and stop give 7 to 12 bits
  always_comb begin
    bad_len = 1'b0;
    for (int p = 0; p < NPORT; p++) begin
      if (o_conv_on[p] && (o_char_len[4*p+:4] < 4'h7 ||
          o_char_len[4*p+:4] > 4'hc)) begin
        bad_len = 1'b1;
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_len_in_range: assert property (!bad_len)
    else $error("character length out of range");
  a_link_down_dark: assert property (i_wan_up == 8'h00 |=> o_rlsd == '0)
    else $error("carrier detect high with all links down");
  a_rlsd_needs_link: assert property (o_rlsd != '0 |-> $past(i_wan_up) != 8'h00)
    else $error("carrier detect without any link");
  a_lead_readback: assert property (i_rd && i_addr == ADR_LEAD |=>
    o_rdata[2*NPORT-1:0] == {$past(o_cts), $past(o_rlsd)})
    else $error("lead readback differs from lead outputs");
  a_bw_ceiling: assert property (i_rd && i_addr == ADR_BW |=>
    o_rdata <= 32'(BW_LIMIT))
    else $error("committed bandwidth above ceiling");
  a_codec_share: assert property (i_rd && i_addr == ADR_CODEC |=>
    o_rdata == 32'(CODEC_KBPS_X10) * $countones(o_codec_req))
    else $error("codec share not matching codec ports");
  a_status_code: assert property (i_rd && i_addr == ADR_STAT |=>
    o_rdata <= 32'(RES_RATE))
    else $error("undefined status code");
  a_owner_code: assert property (o_mux_owner < 4'(NPORT) ||
    o_mux_owner >= OWN_FOREIGN)
    else $error("segment owner code undefined");
endmodule

bind ssm_top ssm_top_checker #(.NPORT(NPORT)) chk_u (.i_clk, .i_reset,
  .i_addr, .i_rd, .o_rdata, .i_wan_up, .o_rlsd, .o_cts, .o_conv_on,
  .o_codec_req, .o_char_len, .o_mux_owner);

/* File: verif/ssm_top_bench.sv */
// Self-checking bench for the subrate slot multiplexer.
// Assumes the far end model and the bound checker.
`timescale 1ns/10ps
module ssm_top_bench;
  import ssm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [7:0] up_ctl = 8'hff;
  logic [9:0] rts_ctl = 10'h000;
  logic [9:0] rrts_ctl = 10'h000;
  logic [7:0] wan_up, is_e1, ts16;
  logic [9:0] rts, rrts, rlsd, cts, rts_fw, conv_on, conv_v14, codec_req;
  logic [39:0] char_len;
  logic [4:0] mts = 5'h00;
  logic [4:0] mseg = 5'h00;
  logic [3:0] owner;
  int failures = 0;
  int n_compared = 0;
  int bw = 0;
  logic [2:0] tw [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h1, 3'h0};
  int tt [6] = '{25, 24, 16, 16, 31, 0};
  logic [2:0] te [6] = '{RES_TS, RES_OK, RES_TS, RES_OK, RES_OK, RES_TS};
  logic [2:0] fr [4] = '{FR_A, FR_B5, FR_B10, FR_B20};
  int cap [4] = '{1, 5, 10, 20};
  logic [3:0] br [3] = '{RT_0K3, RT_1K2, RT_14K4};

  ssm_far_end far_u (.i_clk(clk), .i_up_ctl(up_ctl), .i_rts_ctl(rts_ctl),
    .i_rrts_ctl(rrts_ctl), .o_wan_up(wan_up), .o_wan_is_e1(is_e1),
    .o_wan_ts16_sig(ts16), .o_rts(rts), .o_remote_rts(rrts));
  // Short ms tick keeps the CTS delays to at most a thousand cycles
  ssm_top #(.MS_CYCLES(10)) dut_u (.i_clk(clk), .i_reset(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_wan_up(wan_up), .i_wan_is_e1(is_e1), .i_wan_ts16_sig(ts16),
    .i_rts(rts), .i_remote_rts(rrts), .o_rlsd(rlsd), .o_cts(cts),
    .o_rts_to_remote(rts_fw), .o_conv_on(conv_on), .o_conv_v14(conv_v14),
    .o_codec_req(codec_req), .o_char_len(char_len), .i_mux_ts(mts),
    .i_mux_seg(mseg), .o_mux_owner(owner));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic cfg(input int p, input logic [31:0] w, input logic [2:0] st);
    wr_reg(8'(4 * p), w);
    rc(ADR_STAT, 32'(st));
  endtask
  task automatic own(input int t, input int s, input logic [3:0] e);
    @(posedge clk);
    mts <= 5'(t);
    mseg <= 5'(s);
    tick(2);
    chk(32'(owner), 32'(e));
  endtask
  // Active port word, CTS permanent, character fields zero
  function automatic logic [31:0] cf(input int w, input int t,
      input logic [2:0] f, input logic [3:0] r, input int s,
      input logic [1:0] i = IF_SYNC);
    return {9'h000, i, 5'(s), r, f, 5'(t), 3'(w), 1'b1};
  endfunction
  function automatic int wt(input int r, input int k);
    return r * k * W_NODL;
  endfunction
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(ADR_CFG0, CFG_RST);
    rc(ADR_LEAD, 32'h0);
    rc(ADR_BW, 32'h0);
    rc(8'h30, 32'h0);
    own(2, 0, OWN_FREE);
    for (int i = 0; i < 6; i++) begin
      cfg(0, cf(tw[i], tt[i], FR_A, RT_9K6, 1), te[i]);
    end
    rc(ADR_CFG0, cf(1, 31, FR_A, RT_9K6, 1));
    tick(2);
    chk(32'({cts[0], rlsd[0]}), 32'h3);
    @(posedge clk);
    up_ctl <= 8'h00;
    tick(3);
    chk(32'({cts[0], rlsd[0]}), 32'h2);
    @(posedge clk);
    up_ctl <= 8'hff;
    wr_reg(ADR_CFG0, CFG_RST);
    tick(3);
    chk(32'({cts[0], rlsd[0]}), 32'h0);
    cfg(1, cf(0, 2, FR_B5, RT_28K8, 1), RES_OK);
    bw += wt(288, W_SYNC);
    for (int s = 0; s < 4; s++) own(2, s, s < 3 ? 4'h1 : OWN_FREE);
    cfg(2, cf(0, 2, FR_B5, RT_38K4, 3), RES_SRI);
    cfg(2, cf(0, 2, FR_B5, RT_19K2, 3), RES_OVL);
    own(2, 3, OWN_FREE);
    cfg(2, cf(0, 2, FR_B5, RT_19K2, 4), RES_OK);
    bw += wt(192, W_SYNC);
    own(2, 4, 4'h2);
    cfg(3, cf(1, 2, FR_B5, RT_9K6, 1), RES_WAN);
    for (int i = 0; i < 4; i++) begin
      cfg(3, cf(0, 10 + i, fr[i], RT_2K4, cap[i] + 1), RES_SRI);
      cfg(3, cf(0, 10 + i, fr[i], RT_2K4, cap[i]), RES_OK);
    end
    bw += wt(24, W_SYNC);
    own(13, 19, 4'h3);
    foreach (br[i]) cfg(4, cf(0, 4, FR_A, br[i], 1), RES_RATE);
    cfg(4, cf(0, 4, FR_ADPCM, RT_14K4, 1), RES_OK);
    bw += wt(144, W_SYNC);
    rc(ADR_CODEC, 32'(CODEC_KBPS_X10));
    chk(32'(codec_req), 32'h010);
    cfg(5, cf(0, 5, FR_X50, RT_9K6, 2), RES_OK);
    bw += wt(96, W_SYNC);
    for (int s = 0; s < 4; s++) own(5, 1 + 5 * s, 4'h5);
    own(5, 2, OWN_FREE);
    cfg(6, cf(0, 5, FR_X50, RT_4K8, 11), RES_SRI);
    cfg(6, cf(0, 5, FR_X50, RT_2K4, 7), RES_OVL);
    cfg(6, cf(0, 5, FR_X50, RT_4K8, 3), RES_OK);
    bw += wt(48, W_SYNC);
    own(5, 12, 4'h6);
    wr_reg(ADR_MPTR, 32'h1a0);
    wr_reg(ADR_MOWN, 32'h1);
    own(13, 0, OWN_FOREIGN);
    cfg(7, cf(0, 13, FR_B20, RT_2K4, 1), RES_OVL);
    cfg(7, cf(0, 13, FR_B20, RT_2K4, 2), RES_OK);
    bw += wt(24, W_SYNC);
    // Five data bits, two stops, odd parity
    cfg(8, cf(0, 20, FR_A, RT_2K4, 1, IF_ASYNC) | 32'h0780_0000, RES_OK);
    bw += wt(24, W_ASYNC);
    chk(32'({conv_v14[8], conv_on[8], char_len[35:32]}), 32'h19);
    rc(ADR_BW, 32'(bw));
    cfg(8, cf(0, 20, FR_A, RT_2K4, 1, IF_V14), RES_OK);
    bw += wt(24, W_V14) - wt(24, W_ASYNC);
    chk(32'({conv_v14[8], conv_on[8], char_len[35:32]}), 32'h3a);
    rc(ADR_BW, 32'(bw));
    cfg(8, cf(0, 20, FR_A, RT_2K4, 1) | 32'h0780_0000, RES_OK);
    bw += wt(24, W_SYNC) - wt(24, W_V14);
    chk(32'({conv_v14[8], conv_on[8], char_len[35:32]}), 32'h0);
    cfg(9, cf(0, 21, FR_B5, RT_38K4, 1, IF_ASYNC), RES_BW);
    wr_reg(ADR_OPT, 32'h200);
    cfg(9, cf(0, 21, FR_B5, RT_28K8, 1), RES_BW);
    wr_reg(ADR_OPT, 32'h8_0000);
    cfg(9, cf(0, 21, FR_B5, RT_28K8, 1), RES_BW);
    wr_reg(ADR_OPT, 32'h0);
    cfg(9, cf(0, 21, FR_B5, RT_28K8, 1), RES_OK);
    bw += wt(288, W_SYNC);
    // Brings the total exactly to the ceiling
    cfg(0, cf(0, 22, FR_A, RT_2K4, 1) | {CTS_L30, 29'h0}, RES_OK);
    bw += wt(24, W_SYNC);
    rc(ADR_BW, 32'(bw));
    @(posedge clk);
    rts_ctl <= 10'h001;
    tick(280);
    chk(32'(cts[0]), 32'h0);
    tick(40);
    chk(32'(cts[0]), 32'h1);
    @(posedge clk);
    rts_ctl <= 10'h000;
    tick(3);
    chk(32'(cts[0]), 32'h0);
    cfg(0, cf(0, 22, FR_A, RT_2K4, 1) | {CTS_RL0, 29'h0}, RES_OK);
    @(posedge clk);
    rts_ctl <= 10'h001;
    rrts_ctl <= 10'h001;
    tick(3);
    chk(32'({rts_fw[0], cts[0], rlsd[0]}), 32'h7);
    @(posedge clk);
    rrts_ctl <= 10'h000;
    tick(3);
    chk(32'({rts_fw[0], cts[0], rlsd[0]}), 32'h6);
    cfg(0, cf(0, 22, FR_A, RT_2K4, 1) | {CTS_OFF, 29'h0}, RES_OK);
    tick(2);
    chk(32'({cts[0], rlsd[0]}), 32'h1);
    summarize();
  end
endmodule
